// ### hw/cse_pkg.sv
// Package of constants and types for the channel status and error counter block
package cse_pkg;

	// Register byte offsets
	localparam logic [7:0] FLAGS_OFS = 8'h00;
	localparam logic [7:0] CTRL_OFS = 8'h04;
	localparam logic [7:0] CNT_BASE_OFS = 8'h40;

	// Counter indices
	localparam int CNT_NUM = 22;
	localparam logic [4:0] CI_REJECTS = 5'h00;
	localparam logic [4:0] CI_DATA_SEQ = 5'h01;
	localparam logic [4:0] CI_INB_SEQ = 5'h02;
	localparam logic [4:0] CI_CONN_SEQ = 5'h03;
	localparam logic [4:0] CI_IC_LOST_SRC = 5'h04;
	localparam logic [4:0] CI_TIMEO = 5'h05;
	localparam logic [4:0] CI_DROPPED = 5'h06;
	localparam logic [4:0] CI_SRC_PAR = 5'h07;
	localparam logic [4:0] CI_BAD_ULP = 5'h08;
	localparam logic [4:0] CI_LLRC = 5'h09;
	localparam logic [4:0] CI_DST_PAR = 5'h0a;
	localparam logic [4:0] CI_DST_SEQ = 5'h0b;
	localparam logic [4:0] CI_SYNC = 5'h0c;
	localparam logic [4:0] CI_ILL_BURST = 5'h0d;
	localparam logic [4:0] CI_IC_LOST_DST = 5'h0e;
	localparam logic [4:0] CI_NULL_CONN = 5'h0f;
	localparam logic [4:0] CI_LINK_ERR = 5'h10;
	localparam logic [4:0] CI_XCVR_RESET = 5'h11;

	// Flag bit positions
	localparam int FB_SRC_IC = 0;
	localparam int FB_DST_IC = 1;
	localparam int FB_LOOPBACK = 2;
	localparam int FB_ACCEPT = 4;
	localparam int FB_PKT_IN = 5;
	localparam int FB_REQ_IN = 6;
	localparam int FB_REQ_OUT = 8;
	localparam int FB_CONN_IN = 9;
	localparam int FB_LINK_OP = 16;
	localparam int FB_FLAG_SYNC = 17;
	localparam int FB_FRAME_SYNC = 18;
	localparam int FB_SIG_DET = 19;
	localparam int FB_HW_LSB = 28;

	// Hardware type codes
	localparam logic [3:0] HW_PARALLEL = 4'h0;
	localparam logic [3:0] HW_SERIAL = 4'h1;

	// Control register fields and reset value
	localparam int CB_ACCEPT = 0;
	localparam int CB_LOOPBACK = 1;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;

	// Link state value that means operational
	localparam logic [1:0] LINK_OPERATIONAL = 2'h2;

	// Timing: link indication absence limit and transceiver watchdog
	localparam int CLK_HZ = 125_000_000;
	localparam int ABSENT_MS = 500;
	localparam int ABSENT_CYC = CLK_HZ / 1000 * ABSENT_MS;
	localparam int XCVR_TIMEOUT_MS = 10;
	localparam int XCVR_TIMEOUT_CYC = CLK_HZ / 1000 * XCVR_TIMEOUT_MS;
	localparam int XCVR_RESET_CYC = 16;

	// Live signals from the channel, asynchronous to the board clock
	typedef struct packed {
		logic src_ic;
		logic dst_ic;
		logic dst_packet_in;
		logic dst_request_in;
		logic src_request_out;
		logic src_connect_in;
		logic frame_flag_synced;
		logic framing_bit_synced;
		logic fiber_signal_detected;
		logic xcvr_alive;
		logic [1:0] link_state;
	} cse_live_s;

	// One-cycle event strobes from the channel state machines
	typedef struct packed {
		logic src_reject;
		logic src_data_seq;
		logic src_inbound_seq;
		logic src_conn_seq;
		logic src_ic_lost;
		logic src_timeout;
		logic src_dropped;
		logic src_parity;
		logic dst_llrc;
		logic dst_parity;
		logic dst_seq;
		logic dst_sync;
		logic dst_ill_burst;
		logic dst_ic_lost;
		logic dst_null_conn;
		logic dst_pkt_end;
	} cse_evt_s;

	// Watchdog states; one bit changes per step except XW_WAIT back to XW_RUN
	typedef enum logic [1:0] {
		XW_RUN = 2'b00,
		XW_RESET = 2'b01,
		XW_WAIT = 2'b11
	} cse_xw_e;

endpackage : cse_pkg

// ### hw/cse_top.sv
// Channel status flags and error counters with an AHB-Lite register slave
//
// Overview of operation
// - Flag 0x0001: source sees inbound interconnect
// - Flag 0x0002: destination sees inbound interconnect
// - Flag 0x0010: destination accepting connections
// - Mirror packet, request, request-out, connect flags
// - Flag 0x0004: loopback on serial variant
// - Flag 0x00010000 only in link state 2
// - Flag 0x00020000: alternating frame flag synced
// - Flag 0x00040000: framing overhead bit correct
// - Flag 0x00080000: fiber signal detected
// - Count rejects, timeouts, remote drops, source parity
// - Count source data machine sequence errors
// - Count inbound control ordering errors
// - Count connection machine internal sequence errors
// - Count interconnect loss before source termination
// - Discard and count packets with unbound protocol
// - Drop and count LLRC, parity, sequence errors
// - Count illegal bursts, null connections, sync errors
// - Count drops from interconnect loss
// - Count link indications absent over half second
// - Reset both transceivers when unresponsive; count
// - Hardware type in flags bits 31-28
//
// Chosen here: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module cse_top #(
	parameter bit SERIAL = 1'b1,
	parameter int ABSENT_LIMIT = cse_pkg::ABSENT_CYC,
	parameter int XCVR_LIMIT = cse_pkg::XCVR_TIMEOUT_CYC
)(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire cse_pkg::cse_live_s live,
	input wire cse_pkg::cse_evt_s evt,
	input wire logic [7:0] pkt_ulp_id,
	output logic dst_accepting,
	output logic loopback_en,
	output logic pkt_discard,
	output logic dst_conn_drop,
	output logic xcvr_reset
);
	import cse_pkg::*;

	// Three-stage synchronisers on live signals
	// The possibly metastable first stage is read only by the second
	cse_live_s sync1, sync2, sync3;
	cse_live_s live_q;
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			sync1 <= '0;
			sync2 <= '0;
			sync3 <= '0;
		end
		else
		begin
			sync1 <= live;
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	// Accept a new value once stages two and three agree
	// A bit still settling keeps its old value one more cycle
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
			live_q <= '0;
		else
		begin
			for (int i = 0; i < $bits(cse_live_s); i++)
				if (sync2[i] == sync3[i])
					live_q[i] <= sync3[i];
		end
	end

	// Control register and ULP ownership table
	// The table is cleared at reset, so every identifier starts unbound
	logic [31:0] ctrl;
	logic [255:0] ulp_bound;
	logic [31:0] flags;
	logic link_op;
	assign link_op = SERIAL && (live_q.link_state == LINK_OPERATIONAL);

	// Live flags word, rebuilt every cycle
	// Serial-only flags stay zero on the parallel variant
	always_comb
	begin
		flags = '0;
		flags[FB_SRC_IC] = live_q.src_ic;
		flags[FB_DST_IC] = live_q.dst_ic;
		flags[FB_ACCEPT] = ctrl[CB_ACCEPT];
		flags[FB_PKT_IN] = live_q.dst_packet_in;
		flags[FB_REQ_IN] = live_q.dst_request_in;
		flags[FB_REQ_OUT] = live_q.src_request_out;
		flags[FB_CONN_IN] = live_q.src_connect_in;
		if (SERIAL)
		begin
			flags[FB_LOOPBACK] = ctrl[CB_LOOPBACK];
			flags[FB_LINK_OP] = link_op;
			flags[FB_FLAG_SYNC] = live_q.frame_flag_synced;
			flags[FB_FRAME_SYNC] = live_q.framing_bit_synced;
			flags[FB_SIG_DET] = live_q.fiber_signal_detected;
		end
		flags[31:FB_HW_LSB] = SERIAL ? HW_SERIAL : HW_PARALLEL;
	end

	// Link health monitor: counts one event for each full limit period of continuous absence
	// Any one of the four indications missing makes the link unhealthy
	// The count restarts after each event, so a long outage counts repeatedly
	logic link_healthy;
	logic [31:0] absent_cnt;
	logic link_err_evt;
	assign link_healthy = link_op && live_q.frame_flag_synced && live_q.framing_bit_synced
		&& live_q.fiber_signal_detected;
	always_ff @(posedge ref_clk)
	begin
		if (!rstn || !SERIAL || link_healthy)
		begin
			absent_cnt <= '0;
			link_err_evt <= 1'b0;
		end
		else if (absent_cnt == 32'(ABSENT_LIMIT))
		begin
			absent_cnt <= '0;
			link_err_evt <= 1'b1;
		end
		else
		begin
			absent_cnt <= absent_cnt + 32'h0000_0001;
			link_err_evt <= 1'b0;
		end
	end

	// Transceiver watchdog: resets both chips when one stops answering
	// The true cause cannot be told apart, so bad cabling also ends up here
	cse_xw_e xw_state;
	logic [31:0] xw_cnt;
	logic xcvr_reset_evt;

	// Counter strobe for each firing, on the very condition that starts the reset
	always_ff @(posedge ref_clk)
	begin
		if (!rstn || !SERIAL)
			xcvr_reset_evt <= 1'b0;
		else
			xcvr_reset_evt <= (xw_state == XW_RUN) && !live_q.xcvr_alive
				&& (xw_cnt == 32'(XCVR_LIMIT));
	end

	// Watchdog state, idle count and the reset pulse to both chips
	always_ff @(posedge ref_clk)
	begin
		if (!rstn || !SERIAL)
		begin
			xw_state <= XW_RUN;
			xw_cnt <= '0;
			xcvr_reset <= 1'b0;
		end
		else
		begin
			case (xw_state)
				XW_RUN:
				begin
					if (live_q.xcvr_alive)
						xw_cnt <= '0;
					else if (xw_cnt == 32'(XCVR_LIMIT))
					begin
						xw_state <= XW_RESET;
						xw_cnt <= '0;
						xcvr_reset <= 1'b1;
					end
					else
						xw_cnt <= xw_cnt + 32'h0000_0001;
				end
				XW_RESET:
				begin
					if (xw_cnt == 32'(XCVR_RESET_CYC - 1))
					begin
						xw_state <= XW_WAIT;
						xw_cnt <= '0;
						xcvr_reset <= 1'b0;
					end
					else
						xw_cnt <= xw_cnt + 32'h0000_0001;
				end
				XW_WAIT:
				begin
					xw_state <= XW_RUN;
					xw_cnt <= '0;
				end
				default:
				begin
					xw_state <= XW_RUN;
					xw_cnt <= '0;
					xcvr_reset <= 1'b0;
				end
			endcase
		end
	end

	// Unknown protocol identifier at packet end: discard strobe
	// The receive path throws the packet away when it sees this strobe
	logic bad_ulp;
	assign bad_ulp = evt.dst_pkt_end && !ulp_bound[pkt_ulp_id];
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
			pkt_discard <= 1'b0;
		else
			pkt_discard <= bad_ulp;
	end

	// Connection drop strobe on any of the three receive error causes
	// Each cause is still counted on its own in the counter bank
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
			dst_conn_drop <= 1'b0;
		else
			dst_conn_drop <= evt.dst_llrc || evt.dst_parity || evt.dst_seq;
	end

	// Event vector feeding the counter bank
	// Each cause has a slot of its own; none is merged with another
	logic [CNT_NUM-1:0] cnt_inc;
	always_comb
	begin
		cnt_inc = '0;
		cnt_inc[CI_REJECTS] = evt.src_reject;
		cnt_inc[CI_TIMEO] = evt.src_timeout;
		cnt_inc[CI_DROPPED] = evt.src_dropped;
		cnt_inc[CI_SRC_PAR] = evt.src_parity;
		cnt_inc[CI_DATA_SEQ] = evt.src_data_seq;
		cnt_inc[CI_INB_SEQ] = evt.src_inbound_seq;
		cnt_inc[CI_CONN_SEQ] = evt.src_conn_seq;
		cnt_inc[CI_IC_LOST_SRC] = evt.src_ic_lost;
		cnt_inc[CI_BAD_ULP] = bad_ulp;
		cnt_inc[CI_LLRC] = evt.dst_llrc;
		cnt_inc[CI_DST_PAR] = evt.dst_parity;
		cnt_inc[CI_DST_SEQ] = evt.dst_seq;
		cnt_inc[CI_SYNC] = evt.dst_sync;
		cnt_inc[CI_ILL_BURST] = evt.dst_ill_burst;
		cnt_inc[CI_NULL_CONN] = evt.dst_null_conn;
		cnt_inc[CI_IC_LOST_DST] = evt.dst_ic_lost;
		cnt_inc[CI_LINK_ERR] = link_err_evt;
		cnt_inc[CI_XCVR_RESET] = xcvr_reset_evt;
	end

	// Counter bank, 32-bit wrapping
	// Software never clears them; readers take differences between two reads
	logic [31:0] cnt [CNT_NUM];
	always_ff @(posedge ref_clk)
	begin
		for (int i = 0; i < CNT_NUM; i++)
			if (!rstn)
				cnt[i] <= '0;
			else if (cnt_inc[i])
				cnt[i] <= cnt[i] + 32'h0000_0001;
	end

	// AHB-Lite address phase capture
	// Only whole-word writes are taken; a narrower one could tear a field
	logic dp_valid;
	logic dp_write;
	logic [7:0] dp_addr;
	logic acc_ok;
	assign acc_ok = hsel && hready && htrans[1];
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			dp_valid <= 1'b0;
			dp_write <= 1'b0;
			dp_addr <= '0;
		end
		else
		begin
			dp_valid <= acc_ok;
			dp_write <= hwrite && (hsize == 3'h2);
			dp_addr <= acc_ok ? haddr[7:0] : dp_addr;
		end
	end

	// Control register write in the data phase; only accept and loopback exist
	// Unused bits read back as zero so software can probe the width
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
			ctrl <= CTRL_RST;
		else if (dp_valid && dp_write && dp_addr == CTRL_OFS)
			ctrl <= hwdata & 32'h0000_0003;
	end

	// Protocol ownership table write, one 32-bit slice per word
	// A cleared bit makes the receive path discard packets with that identifier
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
			ulp_bound <= '0;
		else if (dp_valid && dp_write && dp_addr[7:5] == 3'b001)
			ulp_bound[{dp_addr[4:2], 5'h00} +: 32] <= hwdata;
	end

	// Read mux for the address just taken
	// Decoded straight from the address phase so the answer needs no wait state
	// Only the low address byte is decoded, so the map repeats every 256 bytes
	logic [31:0] next_hrdata;
	logic [7:0] ra;
	logic [5:0] ci;
	always_comb
	begin
		ra = haddr[7:0];
		ci = 6'(ra[7:2] - CNT_BASE_OFS[7:2]);
		next_hrdata = '0;
		if (ra == FLAGS_OFS)
			next_hrdata = flags;
		else if (ra == CTRL_OFS)
			next_hrdata = ctrl;
		else if (ra[7:5] == 3'b001)
			next_hrdata = ulp_bound[{ra[4:2], 5'h00} +: 32];
		else if (ra >= CNT_BASE_OFS && ci < 6'(CNT_NUM))
			next_hrdata = cnt[ci[4:0]];
	end

	// Zero-wait response, always OKAY
	// Read data is registered, so it stands only in the data phase cycle
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			hrdata <= '0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
		else
		begin
			hrdata <= (acc_ok && !hwrite) ? next_hrdata : '0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// Control bits mirrored to the channel side from flops
	// A one-cycle lag behind the register is harmless for these slow levels
	always_ff @(posedge ref_clk)
	begin
		if (!rstn)
		begin
			dst_accepting <= 1'b0;
			loopback_en <= 1'b0;
		end
		else
		begin
			dst_accepting <= ctrl[CB_ACCEPT];
			loopback_en <= SERIAL && ctrl[CB_LOOPBACK];
		end
	end

endmodule : cse_top

`default_nettype wire

// ### dv/cse_top_sva.sv
// Checker of bus, pulse and flag timing at the channel status block ports
`timescale 1ns/1ps
`default_nettype none
module cse_top_chk
	import cse_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire cse_pkg::cse_evt_s evt,
	input wire logic dst_accepting,
	input wire logic loopback_en,
	input wire logic pkt_discard,
	input wire logic dst_conn_drop,
	input wire logic xcvr_reset
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);
	// Read requests taken, overall and to the flags word
	wire logic rd_take = hsel && hready && htrans[1] && !hwrite;
	wire logic flag_rd = rd_take && (haddr[7:0] == 8'h00);
	wire logic drop_evt = evt.dst_llrc || evt.dst_parity || evt.dst_seq;
	// Length of the transceiver reset pulse in progress, saturating
	logic [4:0] rst_len;
	always_ff @(posedge ref_clk)
	begin
		if (!rstn || !xcvr_reset)
			rst_len <= '0;
		else if (rst_len != 5'h1f)
			rst_len <= rst_len + 5'h01;
	end
	bus_okay_a: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
	idle_data_a: assert property (!$past(rd_take) |-> hrdata == 32'h0000_0000) else $error("read data outside phase");
	flag_type_a: assert property (flag_rd |=> hrdata[31:20] == 12'h100) else $error("hardware type wrong");
	accept_flag_a: assert property (flag_rd |=> hrdata[4] == dst_accepting) else $error("accept flag wrong");
	loop_flag_a: assert property (flag_rd |=> hrdata[2] == loopback_en) else $error("loopback flag wrong");
	drop_pulse_a: assert property (drop_evt |=> dst_conn_drop) else $error("drop missing");
	drop_cause_a: assert property (dst_conn_drop |-> $past(drop_evt)) else $error("drop without cause");
	discard_cause_a: assert property (pkt_discard |-> $past(evt.dst_pkt_end)) else $error("stray discard");
	xcvr_len_a: assert property ($fell(xcvr_reset) |-> rst_len == 5'(XCVR_RESET_CYC)) else $error("reset length");
	xcvr_max_a: assert property (rst_len <= 5'(XCVR_RESET_CYC)) else $error("reset too long");
endmodule // cse_top_chk
bind cse_top cse_top_chk u_cse_top_chk (.ref_clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata,
	.hreadyout, .hresp, .evt, .dst_accepting, .loopback_en, .pkt_discard, .dst_conn_drop, .xcvr_reset);
`default_nettype wire

// ### dv/cse_remote_node.sv
// Model of the remote channel node driving live levels and event pulses
`timescale 1ns/1ps
`default_nettype none
module cse_remote_node
	import cse_pkg::*;
(
	input wire logic ref_clk,
	output var cse_pkg::cse_live_s live,
	output var cse_pkg::cse_evt_s evt
);
	// Healthy operational link, no connection activity
	initial
	begin
		live = 12'h03e;
		evt = '0;
	end
	// Change live levels just after an edge
	task set_live(input cse_live_s v);
		live <= v;
	endtask
	// Hold an event for n cycles, back to back when n exceeds one
	task pulse(input cse_evt_s e, input int n);
		evt <= e;
		repeat (n) @(posedge ref_clk);
		evt <= '0;
	endtask
endmodule // cse_remote_node
`default_nettype wire

// ### dv/cse_top_tb_top.sv
// Self-checking bench for the channel status block
`timescale 1ns/1ps
`default_nettype none
module cse_top_tb_top;
	import cse_pkg::*;
	logic ref_clk, rstn, hsel, hwrite;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [7:0] pkt_ulp_id;
	logic hreadyout, hresp, dst_accepting, loopback_en, pkt_discard, dst_conn_drop, xcvr_reset;
	cse_live_s live;
	cse_evt_s evt;
	int n_errors = 0;
	int num_checks = 0;
	localparam logic [31:0] BASE = 32'h100f_0000;
	localparam logic [11:0] HEALTHY = 12'h03e;
	cse_top #(.SERIAL(1'b1), .ABSENT_LIMIT(20), .XCVR_LIMIT(20)) u_cse_top (.ref_clk, .rstn, .hsel, .haddr,
		.htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .live, .evt,
		.pkt_ulp_id, .dst_accepting, .loopback_en, .pkt_discard, .dst_conn_drop, .xcvr_reset);
	cse_remote_node u_cse_remote_node (.ref_clk, .live, .evt);
	// Clock source
	initial
	begin
		ref_clk = 0;
		forever #4 ref_clk = ~ref_clk;
	end
	task chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e)
		begin
			n_errors++;
			$display("BAD t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// One single word transfer: address phase, then data phase
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1;
		htrans <= 2'b10;
		hwrite <= w;
		hsize <= 3'h2;
		haddr <= {24'h00_0000, a};
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		hsel <= 0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task rd_chk(input logic [7:0] a, input logic [31:0] e);
		bus(0, a, 32'h0000_0000);
		chk(q, e);
	endtask
	task t_reset;
		rd_chk(8'h00, BASE);
		for (int i = 0; i < 22; i++) rd_chk(8'h40 + 8'(4 * i), 32'h0000_0000);
		$display("test reset done");
	endtask
	task t_flags;
		int lb[10] = '{11, 10, 9, 8, 7, 6, 5, 4, 3, 1};
		int fb[10] = '{0, 1, 5, 6, 8, 9, 17, 18, 19, 16};
		for (int i = 0; i < 10; i++)
		begin
			u_cse_remote_node.set_live(HEALTHY ^ (12'h001 << lb[i]));
			repeat (6) @(posedge ref_clk);
			rd_chk(8'h00, BASE ^ (32'h0000_0001 << fb[i]));
			u_cse_remote_node.set_live(HEALTHY);
			repeat (6) @(posedge ref_clk);
			rd_chk(8'h00, BASE);
		end
		$display("test flags done");
	endtask
	task t_ctrl;
		bus(1, 8'h04, 32'h0000_0003);
		rd_chk(8'h04, 32'h0000_0003);
		rd_chk(8'h00, BASE | 32'h0000_0014);
		chk({30'h0, dst_accepting, loopback_en}, 32'h0000_0003);
		bus(1, 8'h10, 32'hffff_ffff);
		rd_chk(8'h10, 32'h0000_0000);
		bus(1, 8'h04, 32'h0000_0000);
		rd_chk(8'h00, BASE);
		$display("test ctrl done");
	endtask
	task t_counters;
		int ci[15] = '{0, 1, 2, 3, 4, 5, 6, 7, 9, 10, 11, 12, 13, 14, 15};
		for (int k = 0; k < 15; k++)
		begin
			u_cse_remote_node.pulse(cse_evt_s'(16'h8000 >> k), 2);
			@(posedge ref_clk);
			rd_chk(8'h40 + 8'(4 * ci[k]), 32'h0000_0002);
		end
		$display("test counters done");
	endtask
	task t_ulp;
		bus(1, 8'h20, 32'h0000_0020);
		pkt_ulp_id <= 8'h05;
		u_cse_remote_node.pulse(cse_evt_s'(16'h0001), 1);
		@(posedge ref_clk);
		chk({31'h0000_0000, pkt_discard}, 32'h0000_0000);
		rd_chk(8'h60, 32'h0000_0000);
		pkt_ulp_id <= 8'h06;
		u_cse_remote_node.pulse(cse_evt_s'(16'h0001), 1);
		@(posedge ref_clk);
		chk({31'h0000_0000, pkt_discard}, 32'h0000_0001);
		rd_chk(8'h60, 32'h0000_0001);
		$display("test ulp done");
	endtask
	task t_link;
		logic [31:0] c0;
		bus(0, 8'h80, 32'h0000_0000);
		c0 = q;
		u_cse_remote_node.set_live(HEALTHY & 12'hffd);
		repeat (30) @(posedge ref_clk);
		u_cse_remote_node.set_live(HEALTHY);
		repeat (10) @(posedge ref_clk);
		rd_chk(8'h80, c0 + 1);
		u_cse_remote_node.set_live(HEALTHY & 12'hffb);
		repeat (30) @(posedge ref_clk);
		u_cse_remote_node.set_live(HEALTHY);
		repeat (30) @(posedge ref_clk);
		rd_chk(8'h84, 32'h0000_0001);
		$display("test link done");
	endtask
	task complete_run;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		rstn = 0;
		hsel = 0;
		haddr = '0;
		htrans = 2'b00;
		hsize = 3'h0;
		hwrite = 0;
		hwdata = '0;
		pkt_ulp_id = '0;
		repeat (16) @(posedge ref_clk);
		rstn <= 1;
		// Let the live levels pass the synchroniser before the first flags read
		repeat (6) @(posedge ref_clk);
		t_reset;
		t_flags;
		t_ctrl;
		t_counters;
		t_ulp;
		t_link;
		complete_run;
	end
	// Watchdog against a hang
	initial
	begin
		repeat (5000) @(posedge ref_clk);
		n_errors++;
		complete_run;
	end
endmodule // cse_top_tb_top
`default_nettype wire
